// ### pkg/mcr_defs.svh
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// Control register width and host data width
`define MCR_REG_W          12
`define MCR_HOST_W         16

// Field positions within the miscellaneous control register
`define MCR_OUT_INTERLACE  0
`define MCR_RATE_ABOVE_IN  1
`define MCR_STORE_SLEEP    2
`define MCR_FLIP_VERT      3
`define MCR_DOUBLE_BUF     4
`define MCR_WRITE_FLUSH    5
`define MCR_OUTPUT_PATH    6
`define MCR_BYPASS         7
`define MCR_HANDSHAKE_SEL  8
`define MCR_FRAME_LOCK     9
`define MCR_HSYNC_EDGE     10
`define MCR_TRISTATE       11

// Value after hard reset
`define MCR_RESET_VAL      12'h000

// Width of the horizontal active start count
`define MCR_HSTART_W       12

`endif

// ### pkg/mcr_pkg.sv
package mcr_pkg;

  // Output data window sequencer states
  typedef enum logic [1:0] {
    MCR_WIN_IDLE,
    MCR_WIN_WAIT,
    MCR_WIN_ACTIVE
  } mcr_win_t;

  // Which frame boundary swaps the double buffer
  typedef enum logic {
    MCR_SWAP_ON_IN_FRAME,
    MCR_SWAP_ON_OUT_FRAME
  } mcr_swap_t;

endpackage

// ### verilog/mcr_sync3.sv
`timescale 1ns/10ps
`include "mcr_defs.svh"

// Three-stage synchroniser; a change counts once stages two and three agree
module mcr_sync3 (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic [2:0] stage_ff;      // Raw capture chain
  logic [2:0] nxt_stage;     // Next chain contents
  logic       level_ff;      // Accepted level
  logic       nxt_level;     // Next accepted level

  // Shift and accept on agreement of the last two stages
  always_comb begin
    nxt_stage = {stage_ff[1:0], async_i};
    nxt_level = level_ff;
    if (stage_ff[2] == stage_ff[1]) begin
      nxt_level = stage_ff[2];
    end
  end

  // Register the chain
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      stage_ff <= 3'h0;
      level_ff <= 1'b0;
    end else if (ce_i) begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
    end
  end

  assign sync_o = level_ff;

endmodule

// ### verilog/mcr_misc_control.sv
`timescale 1ns/10ps
`include "mcr_defs.svh"

// What this block does
// [RULE1] Both interlace bits set give interlaced output
// [RULE2] Interlaced input, progressive output merges fields
// [RULE3] Software sets rate bit from frame rates
// [RULE4] Rate bit picks the double-buffer swap point
// [RULE5] Sleep bit requests frame store low power
// [RULE6] Host soft-resets after frame store wakes
// [RULE7] Flip bit scans output bottom to top
// [RULE8] Double-buffer bit enables tear-free conversion
// [RULE9] Host holds flush bit during last pixel
// [RULE10] Output disabled ignores controls, moves no data
// [RULE11] Host disables output before reading frame store
// [RULE12] Bypass bit passes input straight to output
// [RULE13] Handshake zero: data only on request
// [RULE14] Handshake one: data after programmed start count
// [RULE15] Frame lock bit locks output to input
// [RULE16] Edge bit picks hsync sampling clock edge
// [RULE17] Tristate bit floats outputs except serial, interrupt
// [RULE18] Soft reset halts paths, keeps this register
// [RULE19] Twelve bits read back, upper bits zero
module mcr_misc_control (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      ce_i,
  input  wire logic                      soft_reset_i,
  input  wire logic                      host_wr_i,
  input  wire logic [`MCR_HOST_W-1:0]    host_wr_data_i,
  output logic      [`MCR_HOST_W-1:0]    host_rd_data_o,
  input  wire logic                      in_interlace_en_i,
  input  wire logic                      in_frame_end_i,
  input  wire logic                      out_frame_end_i,
  input  wire logic                      out_data_request_i,
  input  wire logic                      out_hsync_i,
  input  wire logic [`MCR_HSTART_W-1:0]  out_h_active_start_i,
  output logic                           out_interlaced_o,
  output logic                           deinterlace_merge_o,
  output logic                           double_buffer_active_o,
  output logic                           buffer_swap_o,
  output logic                           read_bank_o,
  output logic                           store_sleep_req_o,
  output logic                           flip_vertical_en_o,
  output logic                           host_write_flush_o,
  output logic                           out_xfer_o,
  output logic                           bypass_sel_o,
  output logic                           frame_lock_en_o,
  output logic                           in_hsync_sample_edge_o,
  output logic                           pin_drive_en_o
);

  logic [`MCR_REG_W-1:0]    ctrl_ff;        // Miscellaneous control register
  logic [`MCR_REG_W-1:0]    nxt_ctrl;       // Next register value
  mcr_pkg::mcr_win_t        win_ff;         // Output window state
  mcr_pkg::mcr_win_t        nxt_win;        // Next window state
  logic [`MCR_HSTART_W-1:0] cnt_ff;         // Clocks since output hsync
  logic [`MCR_HSTART_W-1:0] nxt_cnt;        // Next count
  logic                     bank_ff;        // Bank currently read out
  logic                     nxt_bank;       // Next read bank
  logic                     swap_ff;        // One-cycle swap pulse
  logic                     nxt_swap;       // Next swap pulse
  logic                     req_sync;       // Synchronised data request pin
  logic                     out_run;        // Output path may transfer
  logic                     db_run;         // Double buffering in force
  mcr_pkg::mcr_swap_t       swap_pt;        // Selected swap boundary

  // Pick one field out of the control register
  function automatic logic fld(input logic [`MCR_REG_W-1:0] r, input int pos);
    fld = r[pos];
  endfunction

  // Data request pin crosses in from the outside world
  mcr_sync3 u_req_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .async_i   (out_data_request_i),
    .sync_o    (req_sync)
  );

  // Host write replaces all twelve bits; soft reset leaves them alone
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (host_wr_i) begin
      nxt_ctrl = host_wr_data_i[`MCR_REG_W-1:0]; // [RULE18]
    end
  end

  // Register the control word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= `MCR_RESET_VAL;
    end else if (ce_i) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Readback: upper bits zero
  assign host_rd_data_o = {{(`MCR_HOST_W-`MCR_REG_W){1'b0}}, ctrl_ff}; // [RULE19]

  // Interlace decoding
  assign out_interlaced_o    = fld(ctrl_ff, `MCR_OUT_INTERLACE) & in_interlace_en_i; // [RULE1]
  assign deinterlace_merge_o = ~fld(ctrl_ff, `MCR_OUT_INTERLACE) & in_interlace_en_i; // [RULE2]

  // Straight steering levels for the rest of the device
  assign store_sleep_req_o      = fld(ctrl_ff, `MCR_STORE_SLEEP);   // [RULE5]
  assign flip_vertical_en_o     = fld(ctrl_ff, `MCR_FLIP_VERT);     // [RULE7]
  assign host_write_flush_o     = fld(ctrl_ff, `MCR_WRITE_FLUSH);
  assign bypass_sel_o           = fld(ctrl_ff, `MCR_BYPASS);        // [RULE12]
  assign frame_lock_en_o        = fld(ctrl_ff, `MCR_FRAME_LOCK);    // [RULE15]
  assign in_hsync_sample_edge_o = fld(ctrl_ff, `MCR_HSYNC_EDGE);    // [RULE16]
  assign pin_drive_en_o         = ~fld(ctrl_ff, `MCR_TRISTATE);     // [RULE17]

  // Double buffering only for progressive input, and not in soft reset
  assign db_run = fld(ctrl_ff, `MCR_DOUBLE_BUF) & ~in_interlace_en_i & ~soft_reset_i; // [RULE8]
  assign double_buffer_active_o = db_run;

  // Faster side's frame end closes the bank swap
  assign swap_pt = fld(ctrl_ff, `MCR_RATE_ABOVE_IN) ? mcr_pkg::MCR_SWAP_ON_OUT_FRAME
                                                     : mcr_pkg::MCR_SWAP_ON_IN_FRAME; // [RULE4]

  // Swap decision and bank toggle
  always_comb begin
    nxt_swap = 1'b0;
    nxt_bank = bank_ff;
    if (db_run) begin
      unique case (swap_pt)
        mcr_pkg::MCR_SWAP_ON_OUT_FRAME: begin
          nxt_swap = out_frame_end_i; // [RULE4]
        end
        mcr_pkg::MCR_SWAP_ON_IN_FRAME: begin
          nxt_swap = in_frame_end_i;  // [RULE4]
        end
      endcase
    end
    if (nxt_swap) begin
      nxt_bank = ~bank_ff;
    end
  end

  // Register swap state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      swap_ff <= 1'b0;
      bank_ff <= 1'b0;
    end else if (ce_i) begin
      swap_ff <= nxt_swap;
      bank_ff <= nxt_bank;
    end
  end

  assign buffer_swap_o = swap_ff;
  assign read_bank_o   = bank_ff;

  // Output path runs only when enabled and not held in soft reset
  assign out_run = fld(ctrl_ff, `MCR_OUTPUT_PATH) & ~soft_reset_i; // [RULE10] [RULE18]

  // Output window: count from hsync to the programmed start
  always_comb begin
    nxt_win = win_ff;
    nxt_cnt = cnt_ff;
    if (!out_run || !fld(ctrl_ff, `MCR_HANDSHAKE_SEL)) begin
      // Controls ignored or request mode: window idle
      nxt_win = mcr_pkg::MCR_WIN_IDLE; // [RULE10]
      nxt_cnt = '0;
    end else if (out_hsync_i) begin
      // Each hsync restarts the count
      nxt_win = (out_h_active_start_i == '0) ? mcr_pkg::MCR_WIN_ACTIVE
                                             : mcr_pkg::MCR_WIN_WAIT; // [RULE14]
      nxt_cnt = '0;
    end else begin
      unique case (win_ff)
        mcr_pkg::MCR_WIN_IDLE: begin
          nxt_cnt = '0;
        end
        mcr_pkg::MCR_WIN_WAIT: begin
          // Start data once the count is reached
          nxt_cnt = cnt_ff + 12'h001;
          if (nxt_cnt == out_h_active_start_i) begin
            nxt_win = mcr_pkg::MCR_WIN_ACTIVE; // [RULE14]
          end
        end
        mcr_pkg::MCR_WIN_ACTIVE: begin
          nxt_cnt = cnt_ff;
        end
        default: begin
          nxt_win = mcr_pkg::MCR_WIN_IDLE;
        end
      endcase
    end
  end

  // Register window state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      win_ff <= mcr_pkg::MCR_WIN_IDLE;
      cnt_ff <= '0;
    end else if (ce_i) begin
      win_ff <= nxt_win;
      cnt_ff <= nxt_cnt;
    end
  end

  // Transfer strobe by handshake mode
  always_comb begin
    if (!out_run) begin
      out_xfer_o = 1'b0; // [RULE10]
    end else if (fld(ctrl_ff, `MCR_HANDSHAKE_SEL)) begin
      out_xfer_o = (win_ff == mcr_pkg::MCR_WIN_ACTIVE); // [RULE14]
    end else begin
      out_xfer_o = req_sync; // [RULE13]
    end
  end

endmodule

// ### test/mcr_host_model.sv
`timescale 1ns/10ps
// Host side: one-cycle write strobe per register write
module mcr_host_model (
  input  wire logic        sys_clk_i,
  output logic             host_wr_o,
  output logic [15:0]      host_wr_data_o
);
  // Bus idle at time zero
  initial begin
    host_wr_o = 1'b0;
    host_wr_data_o = 16'h0000;
  end
  // Strobe held over one rising edge, then dropped
  task automatic wr(input logic [15:0] d);
    host_wr_o <= 1'b1;
    host_wr_data_o <= d;
    @(posedge sys_clk_i);
    #1;
    host_wr_o <= 1'b0;
    host_wr_data_o <= ~d; // Stale word not left on bus
  endtask
endmodule

// ### test/mcr_misc_control_chk.sv
`timescale 1ns/10ps
// Port-level checks on the control register block
module mcr_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic        soft_reset_i,
  input wire logic        host_wr_i,
  input wire logic [15:0] host_wr_data_i,
  input wire logic [15:0] host_rd_data_o,
  input wire logic        in_interlace_en_i,
  input wire logic        in_frame_end_i,
  input wire logic        out_frame_end_i,
  input wire logic        out_interlaced_o,
  input wire logic        deinterlace_merge_o,
  input wire logic        double_buffer_active_o,
  input wire logic        buffer_swap_o,
  input wire logic        read_bank_o,
  input wire logic        store_sleep_req_o,
  input wire logic        flip_vertical_en_o,
  input wire logic        out_xfer_o,
  input wire logic        bypass_sel_o,
  input wire logic        frame_lock_en_o,
  input wire logic        in_hsync_sample_edge_o,
  input wire logic        pin_drive_en_o
);
  // One domain, synchronous low reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire [15:0] rd = host_rd_data_o; // Readback
  wire        fe = rd[1] ? out_frame_end_i : in_frame_end_i; // Chosen frame end
  a_write_readback: assert property (ce_i && host_wr_i |=>
    rd == ($past(host_wr_data_i) & 16'h0fff)) else $error("readback");
  a_soft_keeps_reg: assert property (soft_reset_i && !host_wr_i |=> $stable(rd))
    else $error("soft reset");
  a_interlace_out: assert property (out_interlaced_o == (rd[0] && in_interlace_en_i))
    else $error("interlace");
  a_merge_fields: assert property (deinterlace_merge_o == (!rd[0] && in_interlace_en_i))
    else $error("merge");
  a_sleep_flip: assert property ({flip_vertical_en_o, store_sleep_req_o} == rd[3:2])
    else $error("sleep or flip");
  a_pin_float: assert property (pin_drive_en_o == !rd[11]) else $error("tristate");
  a_steer_bits: assert property (
    {in_hsync_sample_edge_o, frame_lock_en_o, bypass_sel_o} == {rd[10], rd[9], rd[7]})
    else $error("steering bits");
  a_swap_point: assert property (ce_i && double_buffer_active_o && fe |=>
    buffer_swap_o && read_bank_o != $past(read_bank_o)) else $error("swap");
  a_swap_quiet: assert property (ce_i && !double_buffer_active_o |=> !buffer_swap_o)
    else $error("swap while off");
  a_xfer_off: assert property (!rd[6] || soft_reset_i |-> !out_xfer_o) else $error("xfer");
  c_swap: cover property (buffer_swap_o);
  c_xfer: cover property ($rose(out_xfer_o));
  c_write: cover property (ce_i && host_wr_i);
  c_soft_write: cover property (soft_reset_i && host_wr_i);
endmodule

bind mcr_misc_control mcr_chk mcr_chk_i (
  .sys_clk_i              (sys_clk_i),
  .rst_b_i                (rst_b_i),
  .ce_i                   (ce_i),
  .soft_reset_i           (soft_reset_i),
  .host_wr_i              (host_wr_i),
  .host_wr_data_i         (host_wr_data_i),
  .host_rd_data_o         (host_rd_data_o),
  .in_interlace_en_i      (in_interlace_en_i),
  .in_frame_end_i         (in_frame_end_i),
  .out_frame_end_i        (out_frame_end_i),
  .out_interlaced_o       (out_interlaced_o),
  .deinterlace_merge_o    (deinterlace_merge_o),
  .double_buffer_active_o (double_buffer_active_o),
  .buffer_swap_o          (buffer_swap_o),
  .read_bank_o            (read_bank_o),
  .store_sleep_req_o      (store_sleep_req_o),
  .flip_vertical_en_o     (flip_vertical_en_o),
  .out_xfer_o             (out_xfer_o),
  .bypass_sel_o           (bypass_sel_o),
  .frame_lock_en_o        (frame_lock_en_o),
  .in_hsync_sample_edge_o (in_hsync_sample_edge_o),
  .pin_drive_en_o         (pin_drive_en_o)
);

// ### test/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the control register block
module tb_top;
  logic [15:0] host_wr_data_i, host_rd_data_o;
  logic [11:0] out_h_active_start_i;
  logic        sys_clk_i, rst_b_i, ce_i, soft_reset_i, host_wr_i, in_interlace_en_i;
  logic        in_frame_end_i, out_frame_end_i, out_data_request_i, out_hsync_i;
  logic        out_interlaced_o, deinterlace_merge_o, double_buffer_active_o;
  logic        buffer_swap_o, read_bank_o, store_sleep_req_o, flip_vertical_en_o;
  logic        host_write_flush_o, out_xfer_o, bypass_sel_o, frame_lock_en_o;
  logic        in_hsync_sample_edge_o, pin_drive_en_o;
  int          error_cnt = 0;
  int          samples_checked = 0;
  // Row: word written, input interlace, expected flags
  typedef struct packed {logic [11:0] d; logic il; logic [8:0] e;} mcr_row_t;
  mcr_row_t    rows [4] = '{'{12'h001, 1'b1, 9'h101}, '{12'h000, 1'b1, 9'h081},
                            '{12'hfac, 1'b0, 9'h07e}, '{12'h053, 1'b0, 9'h001}};
  // Decoded flags in row order
  wire [8:0]   flags = {out_interlaced_o, deinterlace_merge_o, store_sleep_req_o,
    flip_vertical_en_o, host_write_flush_o, bypass_sel_o, frame_lock_en_o,
    in_hsync_sample_edge_o, pin_drive_en_o};
  mcr_misc_control mcr_misc_control_i (
    .sys_clk_i              (sys_clk_i),
    .rst_b_i                (rst_b_i),
    .ce_i                   (ce_i),
    .soft_reset_i           (soft_reset_i),
    .host_wr_i              (host_wr_i),
    .host_wr_data_i         (host_wr_data_i),
    .host_rd_data_o         (host_rd_data_o),
    .in_interlace_en_i      (in_interlace_en_i),
    .in_frame_end_i         (in_frame_end_i),
    .out_frame_end_i        (out_frame_end_i),
    .out_data_request_i     (out_data_request_i),
    .out_hsync_i            (out_hsync_i),
    .out_h_active_start_i   (out_h_active_start_i),
    .out_interlaced_o       (out_interlaced_o),
    .deinterlace_merge_o    (deinterlace_merge_o),
    .double_buffer_active_o (double_buffer_active_o),
    .buffer_swap_o          (buffer_swap_o),
    .read_bank_o            (read_bank_o),
    .store_sleep_req_o      (store_sleep_req_o),
    .flip_vertical_en_o     (flip_vertical_en_o),
    .host_write_flush_o     (host_write_flush_o),
    .out_xfer_o             (out_xfer_o),
    .bypass_sel_o           (bypass_sel_o),
    .frame_lock_en_o        (frame_lock_en_o),
    .in_hsync_sample_edge_o (in_hsync_sample_edge_o),
    .pin_drive_en_o         (pin_drive_en_o)
  );
  mcr_host_model mcr_host_model_i (
    .sys_clk_i      (sys_clk_i),
    .host_wr_o      (host_wr_i),
    .host_wr_data_o (host_wr_data_i)
  );
  // 100 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Step past n rising edges
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Register write, then one idle edge
  task automatic wr(input logic [15:0] d);
    mcr_host_model_i.wr(d);
    tick();
  endtask
  // One-cycle pulse
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  // Verdict and stop
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {rst_b_i, soft_reset_i, in_interlace_en_i, in_frame_end_i} = 4'h0;
    {out_frame_end_i, out_data_request_i, out_hsync_i} = 3'h0;
    ce_i = 1'b1;
    out_h_active_start_i = 12'h002;
    tick(3);
    rst_b_i = 1'b1;
    chk("rd", 16'h0000, host_rd_data_o);
    foreach (rows[i]) begin
      in_interlace_en_i = rows[i].il;
      wr({4'hf, rows[i].d});
      chk("rd", {4'h0, rows[i].d}, host_rd_data_o);
      chk("flags", 16'(rows[i].e), 16'(flags));
    end
    // Request mode, soft reset, output disable
    wr(16'h0040);
    out_data_request_i = 1'b1;
    tick(3);
    chk("xfer c3", 1'b0, out_xfer_o);
    tick();
    chk("xfer c4", 1'b1, out_xfer_o);
    soft_reset_i = 1'b1;
    wr(16'h0041);
    chk("rd soft", 16'h0041, host_rd_data_o);
    chk("xfer soft", 1'b0, out_xfer_o);
    soft_reset_i = 1'b0;
    tick(4);
    chk("xfer on", 1'b1, out_xfer_o);
    wr(16'h0001);
    chk("xfer off", 1'b0, out_xfer_o);
    out_data_request_i = 1'b0;
    // Handshake mode, start count of two
    wr(16'h0140);
    pulse(out_hsync_i);
    chk("hs c1", 1'b0, out_xfer_o);
    tick();
    chk("hs c2", 1'b0, out_xfer_o);
    tick();
    chk("hs c3", 1'b1, out_xfer_o);
    // Double buffer swap points
    wr(16'h0012);
    chk("db on", 1'b1, double_buffer_active_o);
    pulse(in_frame_end_i);
    chk("swap in", 1'b0, buffer_swap_o);
    pulse(out_frame_end_i);
    chk("swap out", 1'b1, buffer_swap_o);
    chk("bank", 1'b1, read_bank_o);
    wr(16'h0010);
    pulse(in_frame_end_i);
    chk("bank in", 1'b0, read_bank_o);
    in_interlace_en_i = 1'b1;
    #1;
    chk("db ilace", 1'b0, double_buffer_active_o);
    // Mid-run reset with bank flipped and register non-zero
    in_interlace_en_i = 1'b0;
    pulse(in_frame_end_i);
    chk("bank pre", 1'b1, read_bank_o);
    rst_b_i = 1'b0;
    tick(2);
    rst_b_i = 1'b1;
    chk("rd rst", 16'h0000, host_rd_data_o);
    chk("bank rst", 1'b0, read_bank_o);
    chk("pins rst", 1'b1, pin_drive_en_o);
    chk("db rst", 1'b0, double_buffer_active_o);
    end_of_test();
  end
endmodule
